// File: tsp_thermal_shunt_protection.sv
// Purpose: Thermal and shunt protection, mask nesting,
//          AHB-Lite slave.
// Assumes: Sensor inputs synchronous to hclk; stored words stable at reset.
// Notes:   Zero wait states; all responses OKAY.
// How it works
// - Trip mask bit 2 enables trip and event on thermistor switch low.
// - Trip mask bit 3 enables trip and event on motor over-temperature.
// - Trip mask bit 4 enables trip and event on drive over-temperature.
// - No program running: enabled thermal condition cuts power.
// - Running, thermal vector zero: enabled condition still cuts power.
// - Thermal vector nonzero: no trip, system interrupt if event mask bit 5.
// - Conditions checked once per check period, not continuously.
// - At startup trip mask bits 4..2 load from word 5 if word 0 matches revision.
// - Shunt limit resets to zero; zero disables shunt monitoring.
// - Nonzero limit: shunt load monitored at the check rate.
// - Limit 400 means 0.5 s continuous shunting, 8000 means 10 s.
// - Interpreter stopped: shunt load at limit cuts power.
// - Running, shunt vector zero: power cut at the limit.
// - Shunt vector nonzero: system interrupt instead, enabled by mask bit 6.
// - Nesting mode 0 is normal handling and is the value after reset.
// - Mode 1: on interrupt push input and system masks, then clear both.
// - Mode 1 return pops saved masks and ORs in the return arguments.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "tsp_defines.svh"
module tsp_thermal_shunt_protection #(
   parameter int          UNIT_CYCLES  = `TSP_CHECK_UNIT_CYCLES,
   parameter logic [15:0] FW_REVISION  = `TSP_STORED_WORD_REV   // Arbitrary value
)(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // AHB-Lite slave
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   output logic            hreadyout,
   output logic [31:0]     hrdata,
   output logic            hresp,
   // Sensors
   input wire logic        thermistor_switch_input,
   input wire logic        motor_overtemp,
   input wire logic        drive_overtemp,
   input wire logic [7:0]  shunt_load_measure,
   // Stored configuration words
   input wire logic [15:0] stored_word0,
   input wire logic [15:0] stored_word5,
   // Outputs to power stage and program
   output logic            power_stage_enable,
   output logic            sys_interrupt,
   output logic [1:0]      sys_interrupt_cause,
   output logic            irq
);
   tsp_sup_if sup ();

   // Bus state
   tsp_pkg::tsp_bus_e bus_reg;
   tsp_pkg::tsp_bus_e bus_next;
   logic [7:0]        idx_reg;
   logic [7:0]        idx_next;
   logic              wr_reg;
   logic              wr_next;
   logic [31:0]       rdata_reg;
   logic [31:0]       rdata_next;
   // Registers
   logic [15:0]       sys_mask_reg;
   logic [15:0]       sys_mask_next;
   logic [15:0]       in_mask_reg;
   logic [15:0]       in_mask_next;
   logic [15:0]       temp_mask_reg;
   logic [15:0]       temp_mask_next;
   logic [15:0]       limit_reg;
   logic [15:0]       limit_next;
   logic              mode_reg;
   logic              mode_next;
   logic [15:0]       period_reg;
   logic [15:0]       period_next;
   logic [15:0]       tvec_reg;
   logic [15:0]       tvec_next;
   logic [15:0]       svec_reg;
   logic [15:0]       svec_next;
   logic [2:0]        status_reg;
   logic [2:0]        status_next;
   logic [2:0]        imask_reg;
   logic [2:0]        imask_next;
   logic              run_reg;
   logic              run_next;
   logic              power_reg;
   logic              power_next;
   logic              boot_reg;
   logic              boot_next;
   logic              sysint_reg;
   logic              sysint_next;
   logic [1:0]        cause_reg;
   logic [1:0]        cause_next;
   logic              irq_reg;
   logic              irq_next;
   // Mask stack
   logic [31:0]       stack_reg [`TSP_STACK_DEPTH];
   logic [31:0]       stack_next [`TSP_STACK_DEPTH];
   logic [2:0]        sp_reg;
   logic [2:0]        sp_next;

   // Dispatch for both sources
   function automatic tsp_pkg::tsp_disp_e decide(input logic        hit,
                                                 input logic        running,
                                                 input logic [15:0] vector,
                                                 input logic        enable);
      if (!hit)
         decide = tsp_pkg::TSP_DISP_NONE;
      else if (!running || (vector == 16'h0))
         decide = tsp_pkg::TSP_DISP_TRIP;
      else if (enable)
         decide = tsp_pkg::TSP_DISP_IRQ;
      else
         decide = tsp_pkg::TSP_DISP_NONE;
   endfunction

   // Read mux; unmapped addresses read zero
   function automatic logic [31:0] read_word(input logic [7:0] idx);
      case (idx)
         `TSP_IDX_SYS_MASK:     read_word = {16'h0, sys_mask_reg};
         `TSP_IDX_TEMP_MASK:    read_word = {16'h0, temp_mask_reg};
         `TSP_IDX_SHUNT_LIM:    read_word = {16'h0, limit_reg};
         `TSP_IDX_MODE:         read_word = {31'h0, mode_reg};
         `TSP_IDX_INPUT_MASK:   read_word = {16'h0, in_mask_reg};
         `TSP_IDX_CHECK_PERIOD: read_word = {16'h0, period_reg};
         `TSP_IDX_THERM_VEC:    read_word = {16'h0, tvec_reg};
         `TSP_IDX_SHUNT_VEC:    read_word = {16'h0, svec_reg};
         `TSP_IDX_IRQ_STATUS:   read_word = {29'h0, status_reg};
         `TSP_IDX_IRQ_MASK:     read_word = {29'h0, imask_reg};
         `TSP_IDX_CONTROL:      read_word = {29'h0, power_reg, 1'b0, run_reg};
         `TSP_IDX_IRETURN:      read_word = {29'h0, sp_reg};
         `TSP_IDX_SHUNT_ACC:    read_word = sup.acc;
         default:               read_word = 32'h0;
      endcase
   endfunction

   tsp_supervisor #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_sup (
      .hclk    (hclk),
      .hresetn (hresetn),
      .s       (sup.sup)
   );

   assign sup.period  = period_reg;
   assign sup.limit   = limit_reg;
   assign sup.measure = shunt_load_measure;

   // Bus slave: read data fetched in address phase
   always_comb
   begin
      logic take;
      take       = hsel && hready && htrans[1];
      bus_next   = bus_reg;
      idx_next   = idx_reg;
      wr_next    = 1'b0;
      rdata_next = rdata_reg;
      case (bus_reg)
         tsp_pkg::TSP_BUS_IDLE,
         tsp_pkg::TSP_BUS_DATA:
         begin
            if (take)
            begin
               bus_next   = tsp_pkg::TSP_BUS_DATA;
               idx_next   = haddr[9:2];
               wr_next    = hwrite;
               rdata_next = hwrite ? 32'h0 : read_word(haddr[9:2]);
            end
            else
               bus_next = tsp_pkg::TSP_BUS_IDLE;
         end
         default:
            bus_next = tsp_pkg::TSP_BUS_IDLE;
      endcase
   end

   // Protection, register writes, interrupt nesting
   always_comb
   begin
      logic [2:0]          cond;
      logic                therm_hit;
      logic                wr;
      logic                raise;
      logic                pop;
      logic [31:0]         top;
      tsp_pkg::tsp_disp_e  td;
      tsp_pkg::tsp_disp_e  sd;
      raise          = 1'b0;
      cond           = 3'b000;
      therm_hit      = 1'b0;
      td             = tsp_pkg::TSP_DISP_NONE;
      sd             = tsp_pkg::TSP_DISP_NONE;
      top            = 32'h0;
      wr             = wr_reg && (bus_reg == tsp_pkg::TSP_BUS_DATA);
      sys_mask_next  = sys_mask_reg;
      in_mask_next   = in_mask_reg;
      temp_mask_next = temp_mask_reg;
      limit_next     = limit_reg;
      mode_next      = mode_reg;
      period_next    = period_reg;
      tvec_next      = tvec_reg;
      svec_next      = svec_reg;
      imask_next     = imask_reg;
      run_next       = run_reg;
      power_next     = power_reg;
      status_next    = status_reg;
      boot_next      = 1'b1;
      stack_next     = stack_reg;
      sp_next        = sp_reg;
      pop            = 1'b0;

      // Plain register writes
      if (wr)
      begin
         case (idx_reg)
            `TSP_IDX_SYS_MASK:     sys_mask_next  = hwdata[15:0];
            `TSP_IDX_TEMP_MASK:    temp_mask_next = hwdata[15:0];
            `TSP_IDX_SHUNT_LIM:    limit_next     = hwdata[15:0];
            `TSP_IDX_MODE:         mode_next      = hwdata[0];
            `TSP_IDX_INPUT_MASK:   in_mask_next   = hwdata[15:0];
            `TSP_IDX_CHECK_PERIOD: period_next    = hwdata[15:0];
            `TSP_IDX_THERM_VEC:    tvec_next      = hwdata[15:0];
            `TSP_IDX_SHUNT_VEC:    svec_next      = hwdata[15:0];
            `TSP_IDX_IRQ_STATUS:   status_next    = status_reg & ~hwdata[2:0];
            `TSP_IDX_IRQ_MASK:     imask_next     = hwdata[2:0];
            `TSP_IDX_CONTROL:
            begin
               run_next = hwdata[`TSP_CTL_RUN_BIT];
               if (hwdata[`TSP_CTL_REARM_BIT])
                  power_next = 1'b1;
            end
            `TSP_IDX_IRETURN:      pop = mode_reg;
            default:               ;
         endcase
      end

      // Trip mask default, once after reset
      if (!boot_reg && (stored_word0 == FW_REVISION))
         temp_mask_next[4:2] = stored_word5[4:2];

      // Checks act only on the supervision tick
      if (sup.tick)
      begin
         cond[0]   = !thermistor_switch_input && temp_mask_reg[`TSP_TM_SW_BIT];
         cond[1]   = motor_overtemp && temp_mask_reg[`TSP_TM_MOTOR_BIT];
         cond[2]   = drive_overtemp && temp_mask_reg[`TSP_TM_DRIVE_BIT];
         therm_hit = |cond;
         td = decide(therm_hit, run_reg, tvec_reg,
                     sys_mask_reg[`TSP_SM_THERM_BIT]);
         sd = decide(sup.over_limit, run_reg, svec_reg,
                     sys_mask_reg[`TSP_SM_SHUNT_BIT]);
      end

      // Trip wins over a rearm in the same cycle
      if ((td == tsp_pkg::TSP_DISP_TRIP) || (sd == tsp_pkg::TSP_DISP_TRIP))
      begin
         power_next                  = 1'b0;
         status_next[`TSP_IS_TRIP_BIT] = 1'b1;
      end
      // Set wins over a same-cycle clear
      if (therm_hit)
         status_next[`TSP_IS_THERM_BIT] = 1'b1;
      if (sup.over_limit && sup.tick)
         status_next[`TSP_IS_SHUNT_BIT] = 1'b1;

      raise       = (td == tsp_pkg::TSP_DISP_IRQ) || (sd == tsp_pkg::TSP_DISP_IRQ);
      sysint_next = raise;
      cause_next  = {sd == tsp_pkg::TSP_DISP_IRQ, td == tsp_pkg::TSP_DISP_IRQ};

      // Push and clear beats a same-cycle return
      if (raise && mode_reg)
      begin
         if (sp_reg < 3'(`TSP_STACK_DEPTH))
         begin
            stack_next[sp_reg[1:0]] = {sys_mask_reg, in_mask_reg};
            sp_next                 = sp_reg + 3'h1;
         end
         in_mask_next  = 16'h0;
         sys_mask_next = 16'h0;
      end
      else if (pop)
      begin
         if (sp_reg != 3'h0)
         begin
            top     = stack_reg[2'(sp_reg - 3'h1)];
            sp_next = sp_reg - 3'h1;
         end
         in_mask_next  = top[15:0] | hwdata[15:0];
         sys_mask_next = top[31:16] | hwdata[31:16];
      end

      irq_next = |(status_next & imask_next);
   end

   // Bus registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_reg   <= tsp_pkg::TSP_BUS_IDLE;
         idx_reg   <= 8'h00;
         wr_reg    <= 1'b0;
         rdata_reg <= 32'h0;
      end
      else
      begin
         bus_reg   <= bus_next;
         idx_reg   <= idx_next;
         wr_reg    <= wr_next;
         rdata_reg <= rdata_next;
      end
   end

   // Protection and mask registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sys_mask_reg  <= 16'h0000;
         in_mask_reg   <= 16'h0000;
         temp_mask_reg <= `TSP_TEMP_MASK_RST;
         limit_reg     <= `TSP_SHUNT_LIM_RST;
         mode_reg      <= `TSP_MODE_RST;
         period_reg    <= `TSP_PERIOD_RST;
         tvec_reg      <= 16'h0000;
         svec_reg      <= 16'h0000;
         status_reg    <= 3'h0;
         imask_reg     <= 3'h0;
         run_reg       <= 1'b0;
         power_reg     <= 1'b1;
         boot_reg      <= 1'b0;
         sysint_reg    <= 1'b0;
         cause_reg     <= 2'h0;
         irq_reg       <= 1'b0;
         sp_reg        <= 3'h0;
         for (int i = 0; i < `TSP_STACK_DEPTH; i++)
            stack_reg[i] <= 32'h0;
      end
      else
      begin
         sys_mask_reg  <= sys_mask_next;
         in_mask_reg   <= in_mask_next;
         temp_mask_reg <= temp_mask_next;
         limit_reg     <= limit_next;
         mode_reg      <= mode_next;
         period_reg    <= period_next;
         tvec_reg      <= tvec_next;
         svec_reg      <= svec_next;
         status_reg    <= status_next;
         imask_reg     <= imask_next;
         run_reg       <= run_next;
         power_reg     <= power_next;
         boot_reg      <= boot_next;
         sysint_reg    <= sysint_next;
         cause_reg     <= cause_next;
         irq_reg       <= irq_next;
         sp_reg        <= sp_next;
         stack_reg     <= stack_next;
      end
   end

   // Outputs straight from flip-flops; hreadyout and hresp are constants
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign hrdata              = rdata_reg;
   assign power_stage_enable  = power_reg;
   assign sys_interrupt       = sysint_reg;
   assign sys_interrupt_cause = cause_reg;
   assign irq                 = irq_reg;
endmodule

// File: tsp_defines.svh
// Purpose: Constants of the thermal and shunt protection block.
// Assumes: Byte address is index * 4.
// Notes:   Definitions only; included by bare name.
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// Register indices (byte address is index * 4)
`define TSP_IDX_SYS_MASK     8'h04
`define TSP_IDX_TEMP_MASK    8'h06
`define TSP_IDX_SHUNT_LIM    8'h07
`define TSP_IDX_MODE         8'h08
`define TSP_IDX_INPUT_MASK   8'h10
`define TSP_IDX_CHECK_PERIOD 8'h11
`define TSP_IDX_THERM_VEC    8'h12
`define TSP_IDX_SHUNT_VEC    8'h13
`define TSP_IDX_IRQ_STATUS   8'h14
`define TSP_IDX_IRQ_MASK     8'h15
`define TSP_IDX_CONTROL      8'h16
`define TSP_IDX_IRETURN      8'h17
`define TSP_IDX_SHUNT_ACC    8'h18

// Thermal trip mask fields
`define TSP_TM_SW_BIT        2
`define TSP_TM_MOTOR_BIT     3
`define TSP_TM_DRIVE_BIT     4
// System event enable mask fields
`define TSP_SM_THERM_BIT     5
`define TSP_SM_SHUNT_BIT     6
// Control register fields
`define TSP_CTL_RUN_BIT      0
`define TSP_CTL_REARM_BIT    1
// Interrupt status fields
`define TSP_IS_THERM_BIT     0
`define TSP_IS_SHUNT_BIT     1
`define TSP_IS_TRIP_BIT      2

// Reset values and stored word revision
`define TSP_SHUNT_LIM_RST    16'h0000
`define TSP_MODE_RST         1'b0
`define TSP_TEMP_MASK_RST    16'h0000
`define TSP_PERIOD_RST       16'h0001
`define TSP_STORED_WORD_REV  16'h0001

// Cycles per ms check unit at 50 MHz
`define TSP_CHECK_UNIT_CYCLES 50000

// Limit 400 = 500 ms of full shunting
`define TSP_SHUNT_LIM_REF    400
`define TSP_SHUNT_REF_MS     500
`define TSP_SHUNT_MEAS_FULL  255
`define TSP_STACK_DEPTH      4

`endif

// File: tsp_pkg.sv
// Purpose: Types shared by the protection block modules.
// Assumes: Constants live in tsp_defines.svh.
// Notes:   One-hot encodings are written out.
package tsp_pkg;

   // Check outcome per source
   typedef enum logic [2:0]
   {
      TSP_DISP_NONE = 3'b001,
      TSP_DISP_TRIP = 3'b010,
      TSP_DISP_IRQ  = 3'b100
   } tsp_disp_e;

   // Bus slave phase
   typedef enum logic [1:0]
   {
      TSP_BUS_IDLE = 2'b01,
      TSP_BUS_DATA = 2'b10
   } tsp_bus_e;

   typedef logic [31:0] tsp_acc_t;

endpackage

// File: tsp_sup_if.sv
// Purpose: Register side to supervisor link.
// Assumes: One clock domain.
// Notes:   tick and over_limit change together.
`timescale 1ns/1ps
interface tsp_sup_if;
   logic [15:0]       period;
   logic [15:0]       limit;
   logic [7:0]        measure;
   logic              tick;
   logic              over_limit;
   tsp_pkg::tsp_acc_t acc;

   modport sup (input period, limit, measure, output tick, over_limit, acc);
   modport ctl (output period, limit, measure, input tick, over_limit, acc);
endinterface

// File: tsp_supervisor.sv
// Purpose: Supervision tick and shunt load accumulator.
// Assumes: period in ms, measure 255 = full shunting.
// Notes:   Accumulator kept in fine units so the limit scale stays exact.
`timescale 1ns/1ps
`include "tsp_defines.svh"
module tsp_supervisor #(
   parameter int UNIT_CYCLES = `TSP_CHECK_UNIT_CYCLES
)(
   // Clock and reset
   input wire logic   hclk,
   input wire logic   hresetn,
   // Link to the register side
   tsp_sup_if.sup     s
);
   logic [31:0]       unit_reg;
   logic [31:0]       unit_next;
   logic [15:0]       ms_reg;
   logic [15:0]       ms_next;
   logic              tick_reg;
   logic              tick_next;
   logic              over_reg;
   logic              over_next;
   tsp_pkg::tsp_acc_t acc_reg;
   tsp_pkg::tsp_acc_t acc_next;

   // Saturate so a long overload cannot wrap small
   function automatic tsp_pkg::tsp_acc_t sat_add(input tsp_pkg::tsp_acc_t a,
                                                 input tsp_pkg::tsp_acc_t b);
      logic [32:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      sat_add = sum[32] ? 32'hffffffff : sum[31:0];
   endfunction

   // Tick every period ms; load accumulator
   always_comb
   begin
      tsp_pkg::tsp_acc_t step;
      tsp_pkg::tsp_acc_t lim_fine;
      logic [15:0]       per;
      step      = 32'h0;
      lim_fine  = 32'h0;
      per       = (s.period == 16'h0) ? 16'h0001 : s.period;
      unit_next = unit_reg + 32'h1;
      ms_next   = ms_reg;
      tick_next = 1'b0;
      acc_next  = acc_reg;
      over_next = over_reg;
      if (unit_reg >= 32'(UNIT_CYCLES - 1))
      begin
         unit_next = 32'h0;
         ms_next   = ms_reg + 16'h1;
         if (ms_reg >= per - 16'h1)
         begin
            ms_next   = 16'h0;
            tick_next = 1'b1;
         end
      end
      if (tick_next)
      begin
         // Fine units per tick: measure * period * 400 per 500 ms
         step = 32'(s.measure) * 32'(per) * 32'(`TSP_SHUNT_LIM_REF);
         if (s.measure != 8'h0)
            acc_next = sat_add(acc_reg, step);
         else
         begin
            step = 32'(`TSP_SHUNT_MEAS_FULL) * 32'(per) * 32'(`TSP_SHUNT_LIM_REF);
            acc_next = (acc_reg > step) ? acc_reg - step : 32'h0;
         end
         lim_fine  = 32'(s.limit) * 32'(`TSP_SHUNT_MEAS_FULL)
                     * 32'(`TSP_SHUNT_REF_MS);
         // Zero limit switches the monitor off
         over_next = (s.limit != 16'h0) && (acc_next >= lim_fine);
      end
   end

   // State registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         unit_reg <= 32'h0;
         ms_reg   <= 16'h0;
         tick_reg <= 1'b0;
         over_reg <= 1'b0;
         acc_reg  <= 32'h0;
      end
      else
      begin
         unit_reg <= unit_next;
         ms_reg   <= ms_next;
         tick_reg <= tick_next;
         over_reg <= over_next;
         acc_reg  <= acc_next;
      end
   end

   assign s.tick       = tick_reg;
   assign s.over_limit = over_reg;
   assign s.acc        = acc_reg;
endmodule

// File: tsp_plant.sv
// Purpose: Sensor and shunt stand-in for the protection block.
// Assumes: The bench sets heat flags and load.
// Notes:   Dead stage puts no load on the shunt.
`timescale 1ns/1ps
module tsp_plant (
   // Bench side
   input wire logic [2:0] heat,
   input wire logic [7:0] load,
   // Device side
   input wire logic       power_stage_enable,
   output logic           thermistor_switch_input,
   output logic           motor_overtemp,
   output logic           drive_overtemp,
   output logic [7:0]     shunt_load_measure
);
   // Switch opens low when hot
   assign {drive_overtemp, motor_overtemp, thermistor_switch_input} = heat ^ 3'h1;
   // Shunt only loaded through a live stage
   assign shunt_load_measure = power_stage_enable ? load : 8'h00;
endmodule

// File: tsp_props.sv
// Purpose: Port assertions of the protection block.
// Assumes: Check ticks at least four cycles apart.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`include "tsp_defines.svh"
module tsp_props (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   // Protection
   input wire logic        thermistor_switch_input,
   input wire logic        motor_overtemp,
   input wire logic        drive_overtemp,
   input wire logic        power_stage_enable,
   input wire logic        sys_interrupt,
   input wire logic [1:0]  sys_interrupt_cause
);
   logic       dph_reg, dwr_reg, take;
   logic [7:0] dix_reg;
   // Address phase taken
   assign take = hsel & hready & htrans[1];
   // Data phase of the last taken request
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         dph_reg <= 1'b0;
         dwr_reg <= 1'b0;
         dix_reg <= 8'h00;
      end
      else if (hready)
      begin
         dph_reg <= take;
         dwr_reg <= take & hwrite;
         dix_reg <= haddr[9:2];
      end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Bus answers and read widths
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   a_rdata_zero: assert property (dph_reg && (dwr_reg || dix_reg == 8'h30)
      |-> hrdata == 32'h0) else $error("hrdata not zero");
   a_limit_upper: assert property (dph_reg && !dwr_reg &&
      dix_reg == `TSP_IDX_SHUNT_LIM |-> hrdata[31:16] == 16'h0) else $error("limit wide");
   a_mode_width: assert property (dph_reg && !dwr_reg &&
      dix_reg == `TSP_IDX_MODE |-> hrdata[31:1] == 31'h0) else $error("mode wide");
   // Power only returns through a rearm write
   a_rearm_only: assert property ($rose(power_stage_enable) |->
      $past(dwr_reg && dix_reg == `TSP_IDX_CONTROL && hwdata[1])) else $error("power rose");
   // Pulses come from ticks, one cycle long
   a_pulse_gap: assert property (sys_interrupt |=> !sys_interrupt [*3])
      else $error("pulse too close");
   a_pulse_cause: assert property (sys_interrupt |-> sys_interrupt_cause != 2'h0)
      else $error("pulse without cause");
   a_therm_cause: assert property (sys_interrupt && sys_interrupt_cause[0] |->
      $past(!thermistor_switch_input || motor_overtemp || drive_overtemp)) else $error("no heat");
   // Main scenarios
   c_trip: cover property ($fell(power_stage_enable));
   c_pulse: cover property (sys_interrupt && sys_interrupt_cause[0]);
   c_rearm: cover property ($rose(power_stage_enable));
endmodule
bind tsp_thermal_shunt_protection tsp_props i_tsp_props (.*);

// File: tsp_tb.sv
// Purpose: Self-checking bench of the protection block.
// Assumes: UNIT_CYCLES 4, check period left at 1.
// Notes:   Stored words give trip mask 0x1c at startup.
`timescale 1ns/1ps
`include "tsp_defines.svh"
module tb;
   // Pins and counters
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0, sys_interrupt_cause;
   logic [2:0]  hsize = 3'h2, heat = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [15:0] stored_word0 = 16'h0001, stored_word5 = 16'h001c;
   logic [7:0]  load = 8'h00, shunt_load_measure;
   logic        hready, hreadyout, hresp, power_stage_enable, sys_interrupt, irq;
   logic        thermistor_switch_input, motor_overtemp, drive_overtemp;
   logic [3:0]  pins;
   int          miscompares = 0, checks = 0;
   assign hready = hreadyout;
   // Cause only counts while pulsing
   assign pins = {power_stage_enable, sys_interrupt, sys_interrupt_cause & {2{sys_interrupt}}};
   // Device and surroundings
   tsp_thermal_shunt_protection #(.UNIT_CYCLES(4)) i_tsp_thermal_shunt_protection (.*);
   tsp_plant i_tsp_plant (.*);
   // 50 MHz clock
   always #10 hclk = ~hclk;
   task automatic chk(input logic [31:0] s, e);
      checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %0t saw %h want %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bounded wait for hready at an edge
   task automatic rdy;
      @(posedge hclk);
      for (int n = 0; n < 8 && hreadyout !== 1'b1; n++)
         @(posedge hclk);
      if (hreadyout !== 1'b1)
      begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, i, 2'h0};
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      chk(q, e);
   endtask
   // Wait for a pin pattern, or check that nothing fires
   task automatic see(input logic [3:0] e, input int n);
      for (int k = 0; k < n && pins !== e; k++)
         @(negedge hclk);
      chk(pins, e);
      @(posedge hclk);
   endtask
   task automatic stay(input int n);
      logic bad;
      bad = 1'b0;
      repeat (n)
      begin
         @(negedge hclk);
         bad |= pins !== 4'h8;
      end
      chk(bad, 1'b0);
      @(posedge hclk);
   endtask
   task automatic s_reset;
      rd(`TSP_IDX_TEMP_MASK, 32'h1c);
      rd(`TSP_IDX_SHUNT_LIM, 32'h0);
      rd(`TSP_IDX_MODE, 32'h0);
      rd(8'h30, 32'h0);
      wr(`TSP_IDX_IRQ_MASK, 32'h7);
   endtask
   // Each source trips only through its own mask bit
   task automatic s_thermal;
      for (int i = 0; i < 3; i++)
      begin
         wr(`TSP_IDX_TEMP_MASK, 32'h4 << ((i + 1) % 3));
         heat <= 3'h1 << i;
         stay(16);
         wr(`TSP_IDX_TEMP_MASK, 32'h4 << i);
         see(4'h0, 16);
         rd(`TSP_IDX_IRQ_STATUS, 32'h5);
         chk(irq, 1'b1);
         heat <= 3'h0;
         wr(`TSP_IDX_IRQ_STATUS, 32'h7);
         wr(`TSP_IDX_CONTROL, 32'h2);
         see(4'h8, 4);
      end
      chk(irq, 1'b0);
   endtask
   // Running program, handler vector and nesting
   task automatic s_vector;
      wr(`TSP_IDX_TEMP_MASK, 32'h10);
      wr(`TSP_IDX_CONTROL, 32'h1);
      heat <= 3'h4;
      see(4'h0, 16);
      wr(`TSP_IDX_THERM_VEC, 32'h1);
      wr(`TSP_IDX_INPUT_MASK, 32'hff);
      wr(`TSP_IDX_MODE, 32'h1);
      wr(`TSP_IDX_CONTROL, 32'h3);
      stay(16);
      wr(`TSP_IDX_SYS_MASK, 32'h20);
      see(4'hd, 16);
      rd(`TSP_IDX_SYS_MASK, 32'h0);
      rd(`TSP_IDX_INPUT_MASK, 32'h0);
      heat <= 3'h0;
      wr(`TSP_IDX_IRETURN, 32'h0001_0100);
      rd(`TSP_IDX_SYS_MASK, 32'h21);
      rd(`TSP_IDX_INPUT_MASK, 32'h1ff);
      rd(`TSP_IDX_IRETURN, 32'h0);
      wr(`TSP_IDX_MODE, 32'h0);
      wr(`TSP_IDX_CONTROL, 32'h0);
      wr(`TSP_IDX_IRQ_STATUS, 32'h7);
   endtask
   // Full load trips after 500 ticks at limit 400
   task automatic s_shunt;
      int n;
      logic [31:0] a, b;
      wr(`TSP_IDX_SHUNT_LIM, 32'h190);
      load <= 8'hff;
      for (n = 0; n < 2100 && power_stage_enable === 1'b1; n++)
         @(negedge hclk);
      chk(n >= 1990 && n <= 2010, 1'b1);
      rd(`TSP_IDX_IRQ_STATUS, 32'h6);
      bus(1'b0, `TSP_IDX_SHUNT_ACC, 32'h0, a);
      repeat (8) @(posedge hclk);
      bus(1'b0, `TSP_IDX_SHUNT_ACC, 32'h0, b);
      chk(b < a, 1'b1);
      wr(`TSP_IDX_SHUNT_VEC, 32'h1);
      wr(`TSP_IDX_SYS_MASK, 32'h40);
      wr(`TSP_IDX_CONTROL, 32'h3);
      see(4'he, 80);
      wr(`TSP_IDX_SHUNT_LIM, 32'h0);
      wr(`TSP_IDX_CONTROL, 32'h3);
      stay(40);
   endtask
   // Hang guard
   initial
   begin
      #200000;
      miscompares++;
      complete_run();
   end
   // Reset, then scenarios
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset();
      s_thermal();
      s_vector();
      s_shunt();
      complete_run();
   end
endmodule
